// ===== event_timestamp_status_pkg.sv
package event_timestamp_status_pkg;
    // Register decode on the management port
    localparam logic [4:0]  STATUS_ADDR   = 5'h1e;
    localparam logic [4:0]  DATA_ADDR     = 5'h1f;
    // Queue geometry
    localparam int          DEPTH         = 8;
    localparam int          UNITS         = 8;
    localparam int          TS_WORDS      = 4;
    localparam logic [3:0]  COUNT_FULL    = 4'h8;
    localparam logic [3:0]  COUNT_EMPTY   = 4'h0;
    localparam logic [2:0]  PTR_RESET     = 3'h0;
    // Status field positions
    localparam int          LOST_LSB      = 8;
    localparam int          LEN_LSB       = 6;
    localparam int          EDGE_BIT      = 5;
    localparam int          UNIT_LSB      = 2;
    localparam int          MULT_BIT      = 1;
    localparam int          DET_BIT       = 0;
    localparam logic [4:0]  RSVD_BITS     = 5'h00;
    localparam logic [10:0] STAT_RESET    = 11'h000;
    // Saturation of the lost counters
    localparam logic [2:0]  LOST_MAX      = 3'h7;
    localparam logic [2:0]  LOST_RESET    = 3'h0;
    // Data word sequence: extended status, then four timestamp words
    localparam logic [2:0]  WORD_EXT      = 3'h0;
    localparam logic [2:0]  WORD_NS_LO    = 3'h1;
    localparam logic [2:0]  WORD_LAST     = 3'h4;
    localparam logic [15:0] WORD_RESET    = 16'h0000;
endpackage : event_timestamp_status_pkg

// ===== event_timestamp_status.sv
// Overview of operation
// - Each status register read on a non-empty queue pops the queue and presents the next event.
// - Status reads zero when no event timestamp is waiting.
// - Bits 10:8 count lost events of the reported unit, saturating at seven.
// - Bits 7:6 give changed low timestamp words minus one versus previous event.
// - Bit 5 gives the edge of the reported unit, one for rising.
// - Bits 4:2 name lowest unit with lost events, else lowest capturing unit.
// - Bit 1 flags coincident events; extended status is then first data word.
// - Bit 0 set whenever an event is presented.
// - Upper five bits ignore writes and read as zero.
// - Extended word holds detect bit 2n and rise bit 2n+1 per unit.
module event_timestamp_status (
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST,
    // Management register port
    input  wire logic [4:0]  REG_ADDR,
    input  wire logic        REG_RD,
    output logic      [15:0] REG_RDATA,
    // Event capture units
    input  wire logic        EVT_STROBE,
    input  wire logic [7:0]  EVT_DET,
    input  wire logic [7:0]  EVT_RISE,
    input  wire logic [29:0] EVT_NS,
    input  wire logic [31:0] EVT_SEC,
    // Queue state
    output logic             EVT_PENDING
);
    localparam int DEPTH    = event_timestamp_status_pkg::DEPTH;
    localparam int UNITS    = event_timestamp_status_pkg::UNITS;
    localparam int TS_WORDS = event_timestamp_status_pkg::TS_WORDS;

    logic [10:0] q_stat       [DEPTH];
    logic [15:0] q_ext        [DEPTH];
    logic [15:0] q_word       [DEPTH][TS_WORDS];
    logic [2:0]  wr_ptr;
    logic [2:0]  rd_ptr;
    logic [3:0]  count;
    logic [2:0]  lost         [UNITS];
    logic [15:0] prev_word    [TS_WORDS];
    logic        pres_valid;
    logic [15:0] pres_ext;
    logic [15:0] pres_word    [TS_WORDS];
    logic [2:0]  word_idx;
    logic [15:0] rdata;
    logic [10:0] next_q_stat  [DEPTH];
    logic [15:0] next_q_ext   [DEPTH];
    logic [15:0] next_q_word  [DEPTH][TS_WORDS];
    logic [2:0]  next_wr_ptr;
    logic [2:0]  next_rd_ptr;
    logic [3:0]  next_count;
    logic [2:0]  next_lost    [UNITS];
    logic [15:0] next_prev_word [TS_WORDS];
    logic        next_pres_valid;
    logic [15:0] next_pres_ext;
    logic [15:0] next_pres_word [TS_WORDS];
    logic [2:0]  next_word_idx;
    logic [15:0] next_rdata;
    logic [15:0] new_word     [TS_WORDS];
    logic [15:0] ext_word;
    logic [2:0]  det_unit;
    logic [2:0]  lost_unit;
    logic [2:0]  rep_unit;
    logic        det_found;
    logic        lost_found;
    logic [1:0]  len;
    logic        mult;
    logic        pop;
    logic        push;
    logic        stat_rd;
    logic        data_rd;

    // Capture side: field encoding of the incoming event
    always_comb begin
        new_word[0] = EVT_NS[15:0];
        new_word[1] = {2'h0, EVT_NS[29:16]};
        new_word[2] = EVT_SEC[15:0];
        new_word[3] = EVT_SEC[31:16];
        for (int u = 0; u < UNITS; u++) begin
            ext_word[2*u]   = EVT_DET[u];
            ext_word[2*u+1] = EVT_RISE[u] & EVT_DET[u];
        end
        det_unit   = 3'h0;
        lost_unit  = 3'h0;
        det_found  = 1'b0;
        lost_found = 1'b0;
        // Lowest index wins, so scan upward and stop at first hit
        for (int u = 0; u < UNITS; u++) begin
            if (!det_found && EVT_DET[u]) begin
                det_unit  = 3'(u);
                det_found = 1'b1;
            end
            if (!lost_found && lost[u] != event_timestamp_status_pkg::LOST_RESET) begin
                lost_unit  = 3'(u);
                lost_found = 1'b1;
            end
        end
        rep_unit = lost_found ? lost_unit : det_unit;
        len = 2'h0;
        for (int w = 0; w < TS_WORDS; w++) begin
            if (new_word[w] != prev_word[w]) begin
                len = 2'(w);
            end
        end
        mult = (EVT_DET & (EVT_DET - 8'h01)) != 8'h00;
    end

    // Queue control and register reads
    always_comb begin
        stat_rd = REG_RD && REG_ADDR == event_timestamp_status_pkg::STATUS_ADDR;
        data_rd = REG_RD && REG_ADDR == event_timestamp_status_pkg::DATA_ADDR;
        pop     = stat_rd && count != event_timestamp_status_pkg::COUNT_EMPTY;
        // A pop in the same cycle frees the slot, so a full queue still accepts
        push    = EVT_STROBE && EVT_DET != 8'h00 &&
                  (count != event_timestamp_status_pkg::COUNT_FULL || pop);
        next_q_stat     = q_stat;
        next_q_ext      = q_ext;
        next_q_word     = q_word;
        next_wr_ptr     = wr_ptr;
        next_rd_ptr     = rd_ptr;
        next_lost       = lost;
        next_prev_word  = prev_word;
        next_pres_valid = pres_valid;
        next_pres_ext   = pres_ext;
        next_pres_word  = pres_word;
        next_word_idx   = word_idx;
        next_rdata      = rdata;
        // Dropped events are counted per unit for the next entry that gets in
        if (EVT_STROBE && !push) begin
            for (int u = 0; u < UNITS; u++) begin
                if (EVT_DET[u] && lost[u] != event_timestamp_status_pkg::LOST_MAX) begin
                    next_lost[u] = lost[u] + 3'h1;
                end
            end
        end
        if (push) begin
            next_q_stat[wr_ptr] = {lost[rep_unit], len, EVT_RISE[rep_unit],
                                   rep_unit, mult, 1'b1};
            next_q_ext[wr_ptr]  = ext_word;
            next_q_word[wr_ptr] = new_word;
            next_wr_ptr         = wr_ptr + 3'h1;
            next_prev_word      = new_word;
            // Only the reported unit's losses are consumed; others wait their turn
            next_lost[rep_unit] = event_timestamp_status_pkg::LOST_RESET;
        end
        if (stat_rd) begin
            if (pop) begin
                next_rdata      = {event_timestamp_status_pkg::RSVD_BITS, q_stat[rd_ptr]};
                next_pres_valid = 1'b1;
                next_pres_ext   = q_ext[rd_ptr];
                next_pres_word  = q_word[rd_ptr];
                next_word_idx   = q_stat[rd_ptr][event_timestamp_status_pkg::MULT_BIT] ?
                                  event_timestamp_status_pkg::WORD_EXT :
                                  event_timestamp_status_pkg::WORD_NS_LO;
                next_rd_ptr     = rd_ptr + 3'h1;
            end else begin
                next_rdata      = event_timestamp_status_pkg::WORD_RESET;
                next_pres_valid = 1'b0;
                next_word_idx   = event_timestamp_status_pkg::WORD_NS_LO;
            end
        end else if (data_rd) begin
            if (!pres_valid) begin
                next_rdata = event_timestamp_status_pkg::WORD_RESET;
            end else if (word_idx == event_timestamp_status_pkg::WORD_EXT) begin
                next_rdata = pres_ext;
            end else begin
                next_rdata = pres_word[2'(word_idx - 3'h1)];
            end
            // Last word repeats rather than wrapping into stale data
            if (word_idx != event_timestamp_status_pkg::WORD_LAST) begin
                next_word_idx = word_idx + 3'h1;
            end
        end else if (REG_RD) begin
            next_rdata = event_timestamp_status_pkg::WORD_RESET;
        end
        next_count = count + {3'h0, push} - {3'h0, pop};
    end

    // State registers
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < DEPTH; i++) begin
                q_stat[i] <= event_timestamp_status_pkg::STAT_RESET;
                q_ext[i]  <= event_timestamp_status_pkg::WORD_RESET;
                for (int w = 0; w < TS_WORDS; w++) begin
                    q_word[i][w] <= event_timestamp_status_pkg::WORD_RESET;
                end
            end
            for (int u = 0; u < UNITS; u++) begin
                lost[u] <= event_timestamp_status_pkg::LOST_RESET;
            end
            for (int w = 0; w < TS_WORDS; w++) begin
                prev_word[w] <= event_timestamp_status_pkg::WORD_RESET;
                pres_word[w] <= event_timestamp_status_pkg::WORD_RESET;
            end
            wr_ptr      <= event_timestamp_status_pkg::PTR_RESET;
            rd_ptr      <= event_timestamp_status_pkg::PTR_RESET;
            count       <= event_timestamp_status_pkg::COUNT_EMPTY;
            pres_valid  <= 1'b0;
            pres_ext    <= event_timestamp_status_pkg::WORD_RESET;
            word_idx    <= event_timestamp_status_pkg::WORD_NS_LO;
            rdata       <= event_timestamp_status_pkg::WORD_RESET;
            EVT_PENDING <= 1'b0;
        end else begin
            q_stat      <= next_q_stat;
            q_ext       <= next_q_ext;
            q_word      <= next_q_word;
            lost        <= next_lost;
            prev_word   <= next_prev_word;
            pres_word   <= next_pres_word;
            wr_ptr      <= next_wr_ptr;
            rd_ptr      <= next_rd_ptr;
            count       <= next_count;
            pres_valid  <= next_pres_valid;
            pres_ext    <= next_pres_ext;
            word_idx    <= next_word_idx;
            rdata       <= next_rdata;
            EVT_PENDING <= next_count != event_timestamp_status_pkg::COUNT_EMPTY;
        end
    end

    assign REG_RDATA = rdata;
endmodule : event_timestamp_status

// ===== event_timestamp_status_asserts.sv
module event_timestamp_status_asserts (
    // Clock and reset
    input wire logic        MCLK,
    input wire logic        RST,
    // Register port and queue state
    input wire logic [4:0]  REG_ADDR,
    input wire logic        REG_RD,
    input wire logic [15:0] REG_RDATA,
    input wire logic        EVT_STROBE,
    input wire logic [7:0]  EVT_DET,
    input wire logic        EVT_PENDING
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       st_rd;
    logic       pop;
    logic       push;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    // Shadow occupancy; a full queue still accepts a push when popped that edge
    assign st_rd = REG_RD && (REG_ADDR == event_timestamp_status_pkg::STATUS_ADDR);
    assign pop   = st_rd && (cnt != 4'h0);
    assign push  = EVT_STROBE && (EVT_DET != 8'h00) && ((cnt != 4'h8) || pop);
    always_comb next_cnt = cnt + {3'h0, push} - {3'h0, pop};
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) cnt <= 4'h0;
        else cnt <= next_cnt;
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    AST_RSVD: assert property (st_rd |=> REG_RDATA[15:11] == 5'h00)
        else $error("reserved status bits set");
    AST_EMPTY: assert property (st_rd && cnt == 4'h0 |=> REG_RDATA == 16'h0000)
        else $error("status not zero on empty queue");
    AST_DET: assert property (pop |=> REG_RDATA[0])
        else $error("presented entry without detect bit");
    AST_MULT: assert property (st_rd ##1 REG_RDATA[1] |-> REG_RDATA[0])
        else $error("coincident flag without detect bit");
    AST_HOLD: assert property (!REG_RD |=> $stable(REG_RDATA))
        else $error("read data moved without a read");
    AST_PEND: assert property (EVT_PENDING == (cnt != 4'h0))
        else $error("pending flag disagrees with occupancy");
    AST_CLEAR: assert property (st_rd && cnt == 4'h0 ##1 REG_RD && REG_ADDR == 5'h1f |=> REG_RDATA == 16'h0)
        else $error("data not zero after empty status read");
    AST_PUSH: assert property (EVT_STROBE && EVT_DET != 8'h00 |=> EVT_PENDING)
        else $error("capture left queue empty");
endmodule : event_timestamp_status_asserts

bind event_timestamp_status event_timestamp_status_asserts event_timestamp_status_asserts_i (.MCLK(MCLK),
    .RST(RST), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .EVT_STROBE(EVT_STROBE),
    .EVT_DET(EVT_DET), .EVT_PENDING(EVT_PENDING));

// ===== event_timestamp_status_bench.sv
module event_timestamp_status_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] st_a = event_timestamp_status_pkg::STATUS_ADDR;
    localparam logic [4:0] dt_a = event_timestamp_status_pkg::DATA_ADDR;
    logic        MCLK = 1'b0, RST = 1'b1, REG_RD = 1'b0, EVT_STROBE = 1'b0, EVT_PENDING, rd_d = 1'b0;
    logic [4:0]  REG_ADDR = 5'h00;
    logic [7:0]  EVT_DET = 8'h00, EVT_RISE = 8'h00;
    logic [15:0] REG_RDATA;
    logic [29:0] EVT_NS = 30'h0;
    logic [31:0] EVT_SEC = 32'h0, seed = 32'h832b667e, r, s;
    logic [63:0] prev = 64'h0, t;
    logic [2:0]  lost [8] = '{default: 3'h0};
    logic [95:0] mq [$];
    logic [15:0] cur [$];
    logic [16:0] eq [$];
    logic        pop_too = 1'b0;
    int          errors = 0, n_checks = 0, ptr = 0;
    always #5 MCLK = ~MCLK;
    event_timestamp_status event_timestamp_status_i (.MCLK(MCLK), .RST(RST), .REG_ADDR(REG_ADDR),
        .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .EVT_STROBE(EVT_STROBE), .EVT_DET(EVT_DET),
        .EVT_RISE(EVT_RISE), .EVT_NS(EVT_NS), .EVT_SEC(EVT_SEC), .EVT_PENDING(EVT_PENDING));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // Capture one event and note the entry the queue should hold
    task cap(input logic [7:0] d, input logic [7:0] rs, input logic [29:0] ns, input logic [31:0] sec);
        logic [63:0] ts;
        logic [15:0] ext;
        logic [1:0]  len;
        int          u;
        ts = {sec, 2'b00, ns};
        REG_RD <= pop_too; EVT_STROBE <= 1'b1; EVT_DET <= d; EVT_RISE <= rs; EVT_NS <= ns; EVT_SEC <= sec;
        if (d != 8'h00 && mq.size() == 8) begin
            for (int i = 0; i < 8; i++) if (d[i] && lost[i] != 3'h7) lost[i] = lost[i] + 3'h1;
        end else if (d != 8'h00) begin
            u = 8;
            for (int i = 7; i >= 0; i--) if (lost[i] != 3'h0) u = i;
            if (u == 8) for (int i = 7; i >= 0; i--) if (d[i]) u = i;
            len = 2'h0;
            for (int k = 1; k < 4; k++) if (ts[16*k +: 16] != prev[16*k +: 16]) len = k[1:0];
            for (int i = 0; i < 8; i++) ext[2*i +: 2] = {d[i] & rs[i], d[i]};
            mq.push_back({5'h00, lost[u], len, rs[u], u[2:0], $countones(d) > 1, 1'b1, ext, ts});
            lost[u] = 3'h0;
            prev = ts;
        end
        @(posedge MCLK);
    endtask : cap
    // Note one read's answer with the pending flag; status pops the model, data walks its words
    task note_rd(input logic [4:0] a);
        logic [95:0] e;
        if (a == st_a) begin
            e = (mq.size() != 0) ? mq.pop_front() : 96'h0;
            cur = {};
            ptr = 0;
            if (e[81]) cur.push_back(e[79:64]);
            for (int k = 0; k < 4; k++) if (e[80]) cur.push_back(e[16*k +: 16]);
            eq.push_back({mq.size() != 0, e[95:80]});
        end else if (a == dt_a) begin
            eq.push_back({mq.size() != 0, (cur.size() == 0 ? 16'h0 : cur[ptr < cur.size() ? ptr : cur.size() - 1])});
            ptr++;
        end else eq.push_back({mq.size() != 0, 16'h0});
    endtask : note_rd
    // One register read
    task rd(input logic [4:0] a);
        EVT_STROBE <= 1'b0; REG_RD <= 1'b1; REG_ADDR <= a;
        note_rd(a);
        @(posedge MCLK);
    endtask : rd
    // Status read and capture on one edge; the pop frees room for the push
    task cap_pop(input logic [7:0] d, input logic [7:0] rs, input logic [29:0] ns, input logic [31:0] sec);
        REG_ADDR <= st_a;
        note_rd(st_a);
        pop_too = 1'b1;
        cap(d, rs, ns, sec);
        pop_too = 1'b0;
    endtask : cap_pop
    task idle(input int n);
        REG_RD <= 1'b0; EVT_STROBE <= 1'b0;
        repeat (n) @(posedge MCLK);
    endtask : idle
    task print_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    // Answers come one edge after the read is taken
    always @(posedge MCLK) begin
        rd_d <= REG_RD;
        if (rd_d) begin
            n_checks++;
            if ({EVT_PENDING, REG_RDATA} !== eq[0]) begin
                errors++;
                $display("ERROR EVT_PENDING and REG_RDATA expected %h seen %h", eq[0], {EVT_PENDING, REG_RDATA});
            end
            void'(eq.pop_front());
        end
    end
    initial begin
        repeat (3000) @(posedge MCLK);
        errors++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge MCLK);
        RST <= 1'b0;
        @(posedge MCLK);
        rd(st_a); rd(dt_a); rd(5'h05); idle(1);
        $display("empty queue test done");
        cap(8'h04, 8'h04, 30'h2345678, 32'h1); rd(st_a); repeat (5) rd(dt_a);
        cap(8'h26, 8'h22, 30'h1, 32'h1); rd(st_a); repeat (6) rd(dt_a); idle(1);
        $display("single and coincident test done");
        for (int k = 0; k < 4; k++) begin
            t = prev ^ (64'h1 << (16 * k));
            cap(8'h02, 8'h00, t[29:0], t[63:32]);
        end
        repeat (4) rd(st_a); idle(1);
        $display("length code test done");
        repeat (8) cap(8'h01, 8'hff, 30'(xs()), xs());
        repeat (10) cap(8'h08, 8'h08, 30'h5, 32'h5);
        cap(8'h30, 8'h00, 30'h6, 32'h6);
        cap_pop(8'h40, 8'h40, 30'h7, 32'h7);
        repeat (8) begin rd(st_a); rd(dt_a); end
        repeat (3) cap(8'h01, 8'h08, 30'(xs()), xs());
        repeat (4) rd(st_a); idle(1);
        $display("overflow test done");
        repeat (300) begin
            r = xs();
            s = xs();
            if (r[0]) cap(r[15:8], r[23:16], s[29:0], xs());
            else rd(r[1] ? st_a : (r[2] ? dt_a : r[7:3]));
        end
        while (mq.size() != 0) rd(st_a);
        idle(2);
        $display("random traffic test done");
        print_verdict();
    end
endmodule : event_timestamp_status_bench
